// ===== acmc_avg.sv
`timescale 1ns/1ps
module acmc_avg
(
    // Clock and reset.
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // Control.
    input  wire logic                       clear,
    input  wire logic                       avg_on,
    // Raw samples.
    input  wire logic                       samp_valid,
    input  wire logic [acmc_pkg::CODE_W-1:0] samp,
    // Finished result.
    output logic                            res_valid,
    output logic [acmc_pkg::CODE_W-1:0]     res
);
    import acmc_pkg::*;

    localparam int SUM_W = CODE_W + AVG_SHIFT;

    logic [SUM_W-1:0]     acc_q;
    logic [AVG_SHIFT-1:0] cnt_q;
    logic                 res_valid_q;
    logic [CODE_W-1:0]    res_q;
    logic [SUM_W-1:0]     sum_d;

    assign sum_d = acc_q + SUM_W'(samp);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q       <= '0;
            cnt_q       <= '0;
            res_valid_q <= 1'b0;
            res_q       <= '0;
        end
        else
        begin
            res_valid_q <= 1'b0;
            if (clear)
            begin
                acc_q <= '0;
                cnt_q <= '0;
            end
            else if (samp_valid && !avg_on)
            begin
                acc_q       <= '0;
                cnt_q       <= '0;
                res_q       <= samp;
                res_valid_q <= 1'b1;
            end
            else if (samp_valid && cnt_q == AVG_SHIFT'(AVG_N - 1))
            begin
                // The mean of sixteen codes stays within the code range.
                acc_q       <= '0;
                cnt_q       <= '0;
                res_q       <= sum_d[SUM_W-1:AVG_SHIFT];
                res_valid_q <= 1'b1;
            end
            else if (samp_valid)
            begin
                acc_q <= sum_d;
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign res_valid = res_valid_q;
    assign res       = res_q;

endmodule : acmc_avg

// ===== acmc_conv_model.sv
`timescale 1ns/1ps
// Converter stand-in: one done pulse per start, after a short or a long latency.
module acmc_conv_model
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control from the block; slow is driven by the testbench.
    input  wire logic       adc_start,
    input  wire logic [2:0] adc_mux,
    input  wire logic       slow,
    // Result to the block.
    output logic            adc_done,
    output logic [9:0]      adc_data
);
    logic       busy_q;
    logic [5:0] wait_q;
    logic [2:0] chan_q;
    logic [3:0] cnt_q;

    // Codes are chan*64 plus a running count mod 16, so any sixteen consecutive samples
    // of one channel average to chan*64+7 whatever their alignment.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q   <= 1'b0;
            wait_q   <= 6'h00;
            chan_q   <= 3'h0;
            cnt_q    <= 4'h0;
            adc_done <= 1'b0;
            adc_data <= 10'h000;
        end
        else
        begin
            adc_done <= 1'b0;
            // Outside the done pulse the data lines toggle, so a stale read shows.
            adc_data <= ~adc_data;
            if (adc_start && !busy_q)
            begin
                busy_q <= 1'b1;
                wait_q <= slow ? 6'h1e : 6'h02;
                chan_q <= adc_mux;
            end
            else if (busy_q && wait_q == 6'h00)
            begin
                busy_q   <= 1'b0;
                adc_done <= 1'b1;
                adc_data <= {1'b0, chan_q, 2'b00, cnt_q};
                cnt_q    <= cnt_q + 4'h1;
            end
            else if (busy_q)
            begin
                wait_q <= wait_q - 6'h01;
            end
        end
    end

endmodule : acmc_conv_model

// ===== acmc_ctrl.sv
`timescale 1ns/1ps
module acmc_ctrl
#(
    parameter int CONV_CYC = acmc_pkg::CONV_CYCLES,
    parameter logic [7:0] DEV_ID = 8'h5a
)
(
    // Clock and reset.
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave.
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [acmc_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Converter core.
    output logic                             adc_start,
    output logic [2:0]                       adc_mux,
    output logic                             adc_is_temp,
    output logic                             atten_bypass,
    output logic                             supply_5v_scale,
    input  wire logic                        adc_done,
    input  wire logic [acmc_pkg::CODE_W-1:0] adc_data
);
    import acmc_pkg::*;

    typedef enum logic [1:0] {ACMC_IDLE, ACMC_CONV, ACMC_STORE} acmc_state_t;

    // The identification value is arbitrary.
    localparam logic [7:0] ID_VAL = DEV_ID;

    logic [7:0]        cfg1_q;
    logic [7:0]        cfg2_q;
    logic [7:0]        sel_q;
    logic [CODE_W-1:0] res_q [NUM_CH];
    logic [2:0]        chan_q;
    acmc_state_t       state_q;
    logic              start_q;
    logic              is_temp_q;
    logic              bypass_q;
    logic              vcc5_q;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic              tick;
    logic              avg_clear_q;
    logic              res_valid;
    logic [CODE_W-1:0] res;
    logic [IDX_W-1:0]  idx;
    logic              aligned;
    logic              access;
    logic              commit;
    logic              avg_on;
    logic              single;
    logic [2:0]        sel_chan;
    logic [2:0]        next_chan;

    assign idx      = paddr[APB_AW-1:2];
    assign aligned  = (paddr[1:0] == 2'b00);
    assign access   = psel && penable;
    assign commit   = access && pready_q;
    assign avg_on   = !cfg2_q[CFG2_AVGOFF_BIT];
    assign single   = cfg2_q[CFG2_SINGLE_BIT];
    assign sel_chan = sel_q[SEL_MSB:SEL_LSB];

    function automatic logic mapped(input logic [IDX_W-1:0] i);
        mapped = (i == IDX_CFG1) || (i == IDX_CFG2) || (i == IDX_SEL_TACH)
              || (i == IDX_STATUS) || (i == IDX_ID)
              || (i >= IDX_RES_BASE && i < IDX_RES_BASE + IDX_W'(NUM_CH));
    endfunction : mapped

    // Voltage channels go through the attenuators; the last three are temperature.
    function automatic logic chan_is_temp(input logic [2:0] c);
        chan_is_temp = (c >= ACMC_CH_REMOTE1);
    endfunction : chan_is_temp

    function automatic logic [31:0] read_reg(input logic [IDX_W-1:0] i);
        logic [IDX_W-1:0] r;
        r        = i - IDX_RES_BASE;
        read_reg = 32'h0000_0000;
        if (i == IDX_CFG1)
            read_reg = {24'h00_0000, cfg1_q};
        else if (i == IDX_CFG2)
            read_reg = {24'h00_0000, cfg2_q};
        else if (i == IDX_SEL_TACH)
            read_reg = {24'h00_0000, sel_q};
        else if (i == IDX_ID)
            read_reg = {24'h00_0000, ID_VAL};
        else if (i == IDX_STATUS)
            read_reg = {27'h000_0000, state_q == ACMC_IDLE ? 1'b0 : 1'b1, chan_q, 1'b0};
        else if (i >= IDX_RES_BASE && i < IDX_RES_BASE + IDX_W'(NUM_CH))
            read_reg = {22'h00_0000, res_q[r[2:0]]};
    endfunction : read_reg

    // APB answers with one wait state, so every access phase is two cycles.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else if (access && !pready_q)
        begin
            pready_q  <= 1'b1;
            pslverr_q <= !(aligned && mapped(idx));
            prdata_q  <= (!pwrite && aligned) ? read_reg(idx) : 32'h0000_0000;
        end
        else
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Writes take effect only at the completing edge of a mapped access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg1_q <= CFG1_RST;
            cfg2_q <= CFG2_RST;
            sel_q  <= SEL_TACH_RST;
        end
        else if (commit && pwrite && aligned)
        begin
            if (idx == IDX_CFG1)
                cfg1_q <= pwdata[7:0];
            if (idx == IDX_CFG2)
                cfg2_q <= pwdata[7:0];
            if (idx == IDX_SEL_TACH)
                sel_q <= pwdata[7:0];
        end
    end

    // Analog controls; the bypassed span is the bare converter range.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bypass_q <= 1'b0;
            vcc5_q   <= 1'b0;
        end
        else
        begin
            bypass_q <= cfg2_q[CFG2_BYPASS_BIT];
            vcc5_q   <= cfg1_q[CFG1_VCC5V_BIT];
        end
    end

    acmc_tick_div #(
        .PERIOD (CONV_CYC)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    acmc_avg u_avg (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (avg_clear_q),
        .avg_on     (avg_on),
        .samp_valid (adc_done && state_q == ACMC_CONV),
        .samp       (adc_data),
        .res_valid  (res_valid),
        .res        (res)
    );

    // Round robin walks all eight channels; single mode pins the selector.
    assign next_chan = single ? sel_chan : chan_q + 3'h1;

    // One conversion per slot; a result closes after sixteen or one samples.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q     <= ACMC_IDLE;
            chan_q      <= ACMC_CH_2V5;
            start_q     <= 1'b0;
            is_temp_q   <= 1'b0;
            res_q       <= '{default: '0};
            avg_clear_q <= 1'b0;
        end
        else
        begin
            start_q     <= 1'b0;
            avg_clear_q <= 1'b0;
            case (state_q)
                ACMC_IDLE:
                begin
                    if (tick)
                    begin
                        // A channel change drops any half-built average.
                        if (single && sel_chan != chan_q)
                        begin
                            chan_q      <= sel_chan;
                            is_temp_q   <= chan_is_temp(sel_chan);
                            avg_clear_q <= 1'b1;
                        end
                        else
                            is_temp_q <= chan_is_temp(chan_q);
                        start_q <= 1'b1;
                        state_q <= ACMC_CONV;
                    end
                end
                ACMC_CONV:
                begin
                    if (adc_done)
                        state_q <= ACMC_STORE;
                end
                ACMC_STORE:
                begin
                    if (res_valid)
                    begin
                        res_q[chan_q] <= res;
                        chan_q        <= next_chan;
                    end
                    state_q <= ACMC_IDLE;
                end
                default:
                    state_q <= ACMC_IDLE;
            endcase
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign adc_start       = start_q;
    assign adc_mux         = chan_q;
    assign adc_is_temp     = is_temp_q;
    assign atten_bypass    = bypass_q;
    assign supply_5v_scale = vcc5_q;

    // Helper: samples taken since the last stored result or average clear.
    logic [4:0] samp_cnt_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            samp_cnt_q <= '0;
        else if (res_valid || avg_clear_q)
            samp_cnt_q <= '0;
        else if (adc_done && state_q == ACMC_CONV)
            samp_cnt_q <= samp_cnt_q + 5'h01;
    end

    a_avg_sixteen: assert property (@(posedge pclk) disable iff (!presetn)
        res_valid && $past(avg_on) |-> samp_cnt_q == 5'(AVG_N))
        else $error("averaged result not made of sixteen samples");

    a_avg_off_direct: assert property (@(posedge pclk) disable iff (!presetn)
        adc_done && state_q == ACMC_CONV && !avg_on && !avg_clear_q
        |=> res_valid && res == $past(adc_data))
        else $error("unaveraged sample not passed straight through");

    a_bypass_follow: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(cfg2_q[CFG2_BYPASS_BIT]) |=> bypass_q == $past(cfg2_q[CFG2_BYPASS_BIT]))
        else $error("attenuator bypass does not follow its bit");

    a_single_pin: assert property (@(posedge pclk) disable iff (!presetn)
        start_q && $past(single) |-> chan_q == $past(sel_chan))
        else $error("single mode converted a channel other than selected");

    a_start_slot: assert property (@(posedge pclk) disable iff (!presetn)
        start_q |-> $past(tick) ##1 !start_q [*3])
        else $error("conversion start outside its slot");

    a_temp_decode: assert property (@(posedge pclk) disable iff (!presetn)
        start_q |-> is_temp_q == (chan_q >= ACMC_CH_REMOTE1))
        else $error("temperature flag disagrees with selector");

    a_vcc_scale: assert property (@(posedge pclk) disable iff (!presetn)
        cfg1_q[CFG1_VCC5V_BIT] ##1 cfg1_q[CFG1_VCC5V_BIT] |-> supply_5v_scale)
        else $error("supply scaling not set for 5 V operation");

    a_reset_modes: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> cfg2_q[6:4] == 3'b000 && !bypass_q)
        else $error("mode bits not clear after reset");

    a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready_q |=> pready_q ##1 !pready_q)
        else $error("apb answer not exactly one wait state");

    a_store_write: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ACMC_STORE && res_valid |=> res_q[$past(chan_q)] == $past(res))
        else $error("finished result not stored for its channel");

    a_rr_advance: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ACMC_STORE && res_valid && !single |=> chan_q == $past(chan_q) + 3'h1)
        else $error("round robin did not move to the next channel");

    a_mux_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ACMC_CONV && !adc_done |=> $stable(chan_q) && $stable(is_temp_q))
        else $error("channel changed during a conversion");

    a_single_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ACMC_STORE && res_valid && single |=> chan_q == $past(sel_chan))
        else $error("single mode left the selected channel");

    a_clear_switch: assert property (@(posedge pclk) disable iff (!presetn)
        avg_clear_q |-> start_q && chan_q == $past(sel_chan))
        else $error("average cleared without a switch to the selector");

    a_bypass_off: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg2_q[CFG2_BYPASS_BIT] ##1 !cfg2_q[CFG2_BYPASS_BIT] |-> !atten_bypass)
        else $error("attenuator bypass active while its bit is clear");

    a_apb_error: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready_q && !(aligned && mapped(idx)) |=> pready_q && pslverr_q)
        else $error("refused access not flagged with its answer");

    a_write_refused: assert property (@(posedge pclk) disable iff (!presetn)
        commit && pwrite && !aligned |=> $stable(cfg1_q) && $stable(cfg2_q) && $stable(sel_q))
        else $error("misaligned write changed a register");

    a_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready_q && !pwrite && !aligned |=> prdata_q == 32'h0000_0000)
        else $error("misaligned read returned data");

endmodule : acmc_ctrl

// ===== acmc_pkg.sv
package acmc_pkg;

    // Bus geometry and register indices; byte address is four times the index.
    localparam int          APB_AW         = 12;
    localparam int          IDX_W          = 10;
    localparam logic [9:0]  IDX_CFG1       = 10'h040;
    localparam logic [9:0]  IDX_RES_BASE   = 10'h020;
    localparam logic [9:0]  IDX_SEL_TACH   = 10'h055;
    localparam logic [9:0]  IDX_CFG2       = 10'h073;
    localparam logic [9:0]  IDX_STATUS     = 10'h07f;
    localparam logic [9:0]  IDX_ID         = 10'h07e;

    // Field positions.
    localparam int          CFG1_VCC5V_BIT = 7;
    localparam int          CFG2_AVGOFF_BIT = 4;
    localparam int          CFG2_BYPASS_BIT = 5;
    localparam int          CFG2_SINGLE_BIT = 6;
    localparam int          SEL_LSB        = 5;
    localparam int          SEL_MSB        = 7;

    // Reset values.
    localparam logic [7:0]  CFG1_RST       = 8'h00;
    localparam logic [7:0]  CFG2_RST       = 8'h00;
    localparam logic [7:0]  SEL_TACH_RST   = 8'h00;

    // Converter code space.
    localparam int          CODE_W         = 10;
    localparam logic [9:0]  CODE_QUARTER   = 10'h100;
    localparam logic [9:0]  CODE_HALF      = 10'h200;
    localparam logic [9:0]  CODE_NOMINAL   = 10'h300;
    localparam logic [9:0]  CODE_FULL      = 10'h3ff;
    localparam int          AVG_N          = 16;
    localparam int          AVG_SHIFT      = 4;

    // Timing: one conversion slot, in microseconds, at the 40 MHz bus clock.
    localparam real         CONV_TIME_US   = 700.0;
    localparam real         CLK_MHZ        = 40.0;
    localparam int          CONV_CYCLES    = int'(CONV_TIME_US * CLK_MHZ);
    localparam real         MEAS_TIME_MS   = 11.0;

    // Channel selector codes.
    typedef enum logic [2:0] {
        ACMC_CH_2V5     = 3'h0,
        ACMC_CH_CORE    = 3'h1,
        ACMC_CH_SUPPLY  = 3'h2,
        ACMC_CH_5V      = 3'h3,
        ACMC_CH_12V     = 3'h4,
        ACMC_CH_REMOTE1 = 3'h5,
        ACMC_CH_LOCAL   = 3'h6,
        ACMC_CH_REMOTE2 = 3'h7
    } acmc_chan_t;

    localparam int          NUM_CH         = 8;

endpackage : acmc_pkg

// ===== acmc_tick_div.sv
`timescale 1ns/1ps
module acmc_tick_div
#(
    parameter int PERIOD = 28000
)
(
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Slot pulse.
    output logic      tick
);
    import acmc_pkg::*;

    localparam int CW = $clog2(PERIOD);

    logic [CW-1:0] cnt_q;
    logic          tick_q;

    // A free counter keeps the slot rate fixed whatever the sequencer does.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (cnt_q == CW'(PERIOD - 1))
        begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    assign tick = tick_q;

endmodule : acmc_tick_div

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import acmc_pkg::*;

    typedef struct packed
    {
        logic       wr;
        logic [9:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
        logic       err;
    } acmc_row_t;

    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        pready, pslverr, ev;
    logic        adc_start, adc_is_temp, atten_bypass, supply_5v_scale, adc_done;
    logic [2:0]  adc_mux;
    logic [9:0]  adc_data, cap;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          n, ch;
    acmc_row_t   rows [7];

    always #12.5 pclk = ~pclk;

    acmc_ctrl #(.CONV_CYC(40)) i_acmc_ctrl
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_start(adc_start),
        .adc_mux(adc_mux), .adc_is_temp(adc_is_temp), .atten_bypass(atten_bypass),
        .supply_5v_scale(supply_5v_scale), .adc_done(adc_done), .adc_data(adc_data)
    );

    acmc_conv_model i_acmc_conv_model
    (
        .pclk(pclk), .presetn(presetn), .adc_start(adc_start), .adc_mux(adc_mux),
        .slow(slow), .adc_done(adc_done), .adc_data(adc_data)
    );

    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task timeout;
        n_mismatch++;
        $display("[ERR] %0t wait ran out", $time);
        print_verdict();
    endtask : timeout

    // Entered just after a rising edge; leaves one edge after the release.
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rdv = prdata;
        ev  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k == 16)
            timeout();
        @(posedge pclk);
    endtask : apb

    task wait_start(output int c);
        for (c = 1; c <= 2000; c++)
        begin
            @(posedge pclk);
            if (adc_start === 1'b1)
                break;
        end
        if (c > 2000)
            timeout();
    endtask : wait_start

    task wait_mux(input logic [2:0] m, output int c);
        for (c = 1; c <= 3000; c++)
        begin
            @(posedge pclk);
            if (adc_mux === m)
                break;
        end
        if (c > 3000)
            timeout();
    endtask : wait_mux

    task wait_done;
        int k;
        for (k = 0; k < 200; k++)
        begin
            @(posedge pclk);
            if (adc_done === 1'b1)
                break;
        end
        cap = adc_data;
        if (k == 200)
            timeout();
    endtask : wait_done

    initial
    begin
        rows[0] = '{1'b0, IDX_CFG2, 8'h00, 8'h00, 1'b0};
        rows[1] = '{1'b0, IDX_SEL_TACH, 8'h00, 8'h00, 1'b0};
        rows[2] = '{1'b0, IDX_CFG1, 8'h00, 8'h00, 1'b0};
        rows[3] = '{1'b1, IDX_SEL_TACH, 8'hff, 8'h00, 1'b0};
        rows[4] = '{1'b0, IDX_SEL_TACH, 8'h00, 8'hff, 1'b0};
        rows[5] = '{1'b1, IDX_SEL_TACH, 8'h00, 8'h00, 1'b0};
        rows[6] = '{1'b0, 10'h3ff, 8'h00, 8'h00, 1'b1};
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        slow    = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i])
        begin
            apb(rows[i].wr, {rows[i].idx, 2'b00}, rows[i].wd);
            if (!rows[i].wr)
            begin
                check(rdv, {24'h0, rows[i].rd});
                check({31'h0, ev}, {31'h0, rows[i].err});
            end
        end
        $display("register rows done");

        // Round robin with averaging: sixteen slots a channel, mean stored.
        wait_mux(3'h1, n);
        wait_mux(3'h2, n);
        check(n, 640);
        repeat (4) @(posedge pclk);
        apb(1'b0, {IDX_RES_BASE + 10'h1, 2'b00}, 8'h00);
        check(rdv, 32'd71);
        $display("averaging done");

        // Single channel, averaging off, slow converter, every selector code.
        slow <= 1'b1;
        apb(1'b1, {IDX_CFG2, 2'b00}, 8'h50);
        for (ch = 0; ch < 8; ch++)
        begin
            apb(1'b1, {IDX_SEL_TACH, 2'b00}, 8'(ch << 5));
            wait_start(n);
            wait_start(n);
            check(n, 40);
            check({29'h0, adc_mux}, ch);
            check({31'h0, adc_is_temp}, (ch >= 5) ? 1 : 0);
            wait_done();
            repeat (3) @(posedge pclk);
            apb(1'b0, {IDX_RES_BASE + 10'(ch), 2'b00}, 8'h00);
            check(rdv, {22'h0, cap});
        end
        $display("single channel done");

        // Bypass and supply scaling; a misaligned write must change nothing.
        apb(1'b1, {IDX_CFG2, 2'b00}, 8'h20);
        apb(1'b1, {IDX_CFG1, 2'b00}, 8'h80);
        @(posedge pclk);
        check({31'h0, atten_bypass}, 1);
        check({31'h0, supply_5v_scale}, 1);
        apb(1'b1, {IDX_CFG2, 2'b01}, 8'h00);
        check({31'h0, ev}, 1);
        repeat (2) @(posedge pclk);
        check({31'h0, atten_bypass}, 1);
        $display("bypass and scaling done");

        // Reset in mid-run returns the mode bits to zero.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({30'h0, atten_bypass, supply_5v_scale}, 0);
        apb(1'b0, {IDX_CFG2, 2'b00}, 8'h00);
        check(rdv, 0);
        $display("second reset done");
        print_verdict();
    end

endmodule : tb_top
